// file: rtl/tsync_cfg.svh
// Constants for the time synchronisation decision logic.
`ifndef TSYNC_CFG_SVH
`define TSYNC_CFG_SVH

`define TS_FINE_W        22
`define TS_COARSE_W      32
`define TS_FINE_ZERO     22'h000000
`define TS_FINE_ONE      22'h000001
`define TS_FINE_TOP      22'h3fffff
`define TS_COARSE_ONE    32'h00000001

`define TS_WIN_HW0       22'h000004
`define TS_WIN_HW1       22'h000040
`define TS_WIN_HW2       22'h000400
`define TS_WIN_HW3       22'h004000

`define TS_GO_SEL0       2'h0
`define TS_GO_SEL1       2'h1
`define TS_GO_SEL2       2'h2
`define TS_GO_SEL_INF    2'h3
`define TS_GO_LIM0       3'h0
`define TS_GO_LIM1       3'h3
`define TS_GO_LIM2       3'h7
`define TS_GO_LIM_INF    3'h7
`define TS_ERR_ZERO      3'h0
`define TS_ERR_ONE       3'h1

`define TS_TO_HALVES     3'h4
`define TS_TO_ZERO       3'h0
`define TS_TO_ONE        3'h1

`define TS_REG_CTRL      3'h0
`define TS_REG_STATUS    3'h1
`define TS_REG_COARSE    3'h2
`define TS_REG_FINE      3'h3
`define TS_REG_TSTAT     3'h4
`define TS_ZERO32        32'h00000000
`define TS_ZERO7         7'h00

`endif

// file: rtl/tsync_pkg.sv
// Types shared by the time synchronisation decision logic.
package tsync_pkg;

    typedef enum logic [1:0] {
        MODE_SER = 2'h0,
        MODE_PAR = 2'h1,
        MODE_SAL = 2'h2
    } mode_t;

    typedef enum logic [1:0] {
        CODE_OK     = 2'h0,
        CODE_MSGERR = 2'h1,
        CODE_SYNERR = 2'h2,
        CODE_FORCED = 2'h3
    } code_t;

    typedef enum logic [1:0] {
        ST_WAIT = 2'h0,
        ST_MSG  = 2'h1,
        ST_BAD  = 2'h2
    } msg_state_t;

    typedef struct packed {
        logic [31:0] coarse;
        logic        init;
        logic [6:0]  flags;
    } msg_t;

    typedef struct packed {
        logic        first_pend;
        logic        drift;
        logic        win_to;
        logic        coarse_to;
        logic        marker_to;
        logic        ext_err;
        logic [2:0]  err_count;
        logic [1:0]  code;
    } status_t;

endpackage

// file: rtl/time_sync_decision_logic.sv
// Decision logic that resynchronises the local elapsed-time counter.
//
// Overview of operation
// - Outside fault input sets external error flag; flag blocks normal synchronisation.
// - Message acquisition continues while fault input or external error flag set.
// - Error flag clears only with fault input, control bit clear and good message.
// - After reset, sync on marker after first valid message, no checks.
// - Normal sync needs valid message, coarse plus one, in window, no error.
// - Error counter at go-threshold forces sync on valid message without error.
// - Valid message with initialisation flag always synchronises.
// - Stand-alone: sync on valid message when external error flag clear.
// - Sync loads coarse, sets fine to lowest bit, copies message flags.
// - Sync decrements nonzero counter, clears drift flag, writes code 00 or 11.
// - Valid message coarse compared with counter coarse plus one: coarse timeout.
// - Window centred on fine wrap, half-widths 4, 64, 1024, 16384 clocks.
// - Stand-alone: no marker timeouts; coarse and window timeouts only flagged.
// - Serial/parallel: marker timeout flag after 1.5 to 2 s; timely marker clears.
// - Serial/parallel sync error: unforced coarse or window timeout, or external error.
// - Sync error: abort, count up, code 10, window flag, load flags, wait.
// - Stand-alone: only external error without initialisation flag is a sync error.
// - Counter increments once per erroneous message and once per sync error.
// - Marker after an erroneous message is ignored and counts nothing.
// - Counter saturates at go-threshold 0, 3 or 7 for codes 00, 01, 10.
// - Go-threshold zero keeps counter at zero and every clean marker updates.
// - Code 11 means infinite threshold; window blocks unless init, first sync or stand-alone; saturates at 7.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tsync_cfg.svh"

module time_sync_decision_logic (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    // Avalon-MM register slave
    input  wire logic [2:0]           avs_address_in,
    input  wire logic                 avs_read_in,
    input  wire logic                 avs_write_in,
    input  wire logic [31:0]          avs_writedata_in,
    output logic      [31:0]          avs_readdata_out,
    output logic                      avs_waitrequest_out,
    // Message decoder side
    input  wire logic                 msg_valid_in,
    input  wire tsync_pkg::msg_t      msg_in,
    input  wire logic                 msg_error_in,
    input  wire logic                 marker_in,
    input  wire logic                 fault_in,
    input  wire logic                 drift_in,
    // Operation selection
    input  wire tsync_pkg::mode_t     mode_in,
    input  wire logic [1:0]           win_sel_in,
    input  wire logic [1:0]           go_sel_in,
    // Results
    output logic                      sync_out,
    output logic                      sync_err_out,
    output logic                      ext_err_out,
    output logic                      marker_to_out
);

    // Elapsed-time counter and held message.
    logic [`TS_COARSE_W-1:0]  coarse;
    logic [`TS_FINE_W-1:0]    fine;
    tsync_pkg::msg_t          held;
    logic [6:0]               tstat;
    tsync_pkg::msg_state_t    state;
    tsync_pkg::msg_state_t    next_state;

    // Status fields and control.
    logic [2:0]               err_count;
    logic [2:0]               next_err_count;
    tsync_pkg::code_t         code;
    logic                     ext_err;
    logic                     marker_to;
    logic                     coarse_to;
    logic                     win_to;
    logic                     drift;
    logic                     first_pend;
    logic                     cto_pend;
    logic                     ctrl_fault;

    // Marker timeout timer counts half periods of the fine counter.
    logic [2:0]               to_count;
    logic                     fine_msb_q;

    // Bus slave state.
    logic                     bus_req;
    logic                     bus_wr;
    logic [31:0]              rd_mux;

    // Window and threshold decode.
    logic [`TS_FINE_W-1:0]    half_width;
    logic [2:0]               go_lim;
    wire                      in_window;
    wire                      is_sal;
    wire                      go_inf;
    wire                      go_hit;
    wire                      have_msg;
    wire                      do_sync;
    wire                      do_serr;
    wire                      forced;
    wire                      fine_wrap;
    wire                      half_tick;
    wire                      to_fire;
    wire                      mark_empty;
    wire                      msg_err_new;
    wire                      count_up;
    wire                      ext_clear;
    wire [`TS_COARSE_W-1:0]   coarse_next;
    tsync_pkg::status_t       status;

    // Half-width of the window around the expected wrap instant.
    always_comb begin
        case (win_sel_in)
            2'h0:    half_width = `TS_WIN_HW0;
            2'h1:    half_width = `TS_WIN_HW1;
            2'h2:    half_width = `TS_WIN_HW2;
            2'h3:    half_width = `TS_WIN_HW3;
            default: half_width = `TS_WIN_HW0;
        endcase
    end

    // Saturation value of the error counter.
    always_comb begin
        case (go_sel_in)
            `TS_GO_SEL0: go_lim = `TS_GO_LIM0;
            `TS_GO_SEL1: go_lim = `TS_GO_LIM1;
            `TS_GO_SEL2: go_lim = `TS_GO_LIM2;
            `TS_GO_SEL_INF: go_lim = `TS_GO_LIM_INF;
            default:     go_lim = `TS_GO_LIM0;
        endcase
    end

    // The window straddles the wrap, so it is the top and bottom of the fine range.
    assign in_window = (fine > (`TS_FINE_TOP - half_width)) || (fine < half_width);

    assign is_sal   = (mode_in == tsync_pkg::MODE_SAL);
    assign go_inf   = (go_sel_in == `TS_GO_SEL_INF);
    // An infinite threshold is never reached, so only init, the first sync or stand-alone mode can override a timeout.
    assign go_hit   = !go_inf && (err_count >= go_lim);
    assign have_msg = (state == tsync_pkg::ST_MSG);

    // A marker with no message held since the last marker counts as an error.
    assign mark_empty = marker_in && (state == tsync_pkg::ST_WAIT);

    assign do_sync = marker_in && have_msg &&
                     (first_pend ||
                      held.init ||
                      (!ext_err &&
                       (is_sal ||
                        go_hit ||
                        (!cto_pend && in_window))));
    assign do_serr = marker_in && have_msg && !do_sync;

    assign forced = cto_pend || !in_window;

    // Only the first error of a message is counted.
    assign msg_err_new = msg_error_in && !marker_in &&
                         (state != tsync_pkg::ST_BAD);

    assign fine_wrap = (fine == `TS_FINE_TOP);
    assign half_tick = (fine[`TS_FINE_W-1] != fine_msb_q);
    assign to_fire   = !is_sal && half_tick && !marker_in &&
                       (to_count == (`TS_TO_HALVES - `TS_TO_ONE));

    assign count_up = do_serr || msg_err_new || mark_empty || to_fire;

    // The fault control bit shares the clear condition with the fault input.
    assign ext_clear = !fault_in && !ctrl_fault && msg_valid_in && !msg_error_in;

    assign coarse_next = coarse + `TS_COARSE_ONE;

    // Message tracking: a marker or timeout consumes whatever was held.
    always_comb begin
        case (state)
            tsync_pkg::ST_WAIT: begin
                if (msg_error_in) begin
                    next_state = tsync_pkg::ST_BAD;
                end else if (msg_valid_in) begin
                    next_state = tsync_pkg::ST_MSG;
                end else begin
                    next_state = tsync_pkg::ST_WAIT;
                end
            end
            tsync_pkg::ST_MSG: begin
                if (msg_error_in) begin
                    next_state = tsync_pkg::ST_BAD;
                end else begin
                    next_state = tsync_pkg::ST_MSG;
                end
            end
            tsync_pkg::ST_BAD: begin
                next_state = tsync_pkg::ST_BAD;
            end
            default: begin
                next_state = tsync_pkg::ST_WAIT;
            end
        endcase
        if (marker_in || to_fire) begin
            next_state = tsync_pkg::ST_WAIT;
        end
    end

    // Error counter next value.
    always_comb begin
        next_err_count = err_count;
        if (do_sync && (err_count != `TS_ERR_ZERO)) begin
            next_err_count = err_count - `TS_ERR_ONE;
        end else if (count_up && (err_count < go_lim)) begin
            next_err_count = err_count + `TS_ERR_ONE;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state     <= tsync_pkg::ST_WAIT;
            err_count <= `TS_ERR_ZERO;
        end else begin
            state     <= next_state;
            err_count <= next_err_count;
        end
    end

    // Elapsed-time counter.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            coarse <= `TS_ZERO32;
            fine   <= `TS_FINE_ZERO;
        end else if (do_sync) begin
            coarse <= held.coarse;
            fine   <= `TS_FINE_ONE;
        end else begin
            fine   <= fine + `TS_FINE_ONE;
            if (fine_wrap) begin
                coarse <= coarse_next;
            end
        end
    end

    // Held message and its coarse check, taken when the message completes.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            held     <= '0;
            cto_pend <= 1'b0;
        end else if (msg_valid_in) begin
            held     <= msg_in;
            cto_pend <= (msg_in.coarse != coarse_next);
        end
    end

    // Message flags land in the time status on both outcomes.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tstat <= `TS_ZERO7;
        end else if (do_sync || do_serr) begin
            tstat <= held.flags;
        end
    end

    // Error code.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            code <= tsync_pkg::CODE_OK;
        end else if (do_sync) begin
            code <= forced ? tsync_pkg::CODE_FORCED : tsync_pkg::CODE_OK;
        end else if (do_serr) begin
            code <= tsync_pkg::CODE_SYNERR;
        end else if (msg_err_new || mark_empty || to_fire) begin
            code <= tsync_pkg::CODE_MSGERR;
        end
    end

    // External error flag; setting wins over clearing.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ext_err <= 1'b0;
        end else if (fault_in) begin
            ext_err <= 1'b1;
        end else if (ext_clear) begin
            ext_err <= 1'b0;
        end
    end

    // First synchronisation after reset needs no checks.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            first_pend <= 1'b1;
        end else if (do_sync) begin
            first_pend <= 1'b0;
        end
    end

    // Timeout flags are refreshed on every judged marker.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            coarse_to <= 1'b0;
            win_to    <= 1'b0;
        end else if (do_sync || do_serr) begin
            coarse_to <= cto_pend;
            win_to    <= !in_window;
        end
    end

    // Drift warning is raised by its source and dropped by a synchronisation.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            drift <= 1'b0;
        end else if (drift_in) begin
            drift <= 1'b1;
        end else if (do_sync) begin
            drift <= 1'b0;
        end
    end

    // Marker timeout: four half periods give between 1.5 and 2 periods.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fine_msb_q <= 1'b0;
            to_count   <= `TS_TO_ZERO;
            marker_to  <= 1'b0;
        end else begin
            fine_msb_q <= fine[`TS_FINE_W-1];
            if (marker_in || is_sal) begin
                to_count <= `TS_TO_ZERO;
            end else if (to_fire) begin
                to_count <= `TS_TO_ZERO;
            end else if (half_tick) begin
                to_count <= to_count + `TS_TO_ONE;
            end
            if (to_fire) begin
                marker_to <= 1'b1;
            end else if (marker_in || is_sal) begin
                marker_to <= 1'b0;
            end
        end
    end

    // Pulse and level outputs.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_out      <= 1'b0;
            sync_err_out  <= 1'b0;
            ext_err_out   <= 1'b0;
            marker_to_out <= 1'b0;
        end else begin
            sync_out      <= do_sync;
            sync_err_out  <= do_serr;
            ext_err_out   <= ext_err;
            marker_to_out <= marker_to;
        end
    end

    // Register read selection.
    assign status = '{first_pend: first_pend, drift: drift, win_to: win_to,
                      coarse_to: coarse_to, marker_to: marker_to, ext_err: ext_err,
                      err_count: err_count, code: code};

    always_comb begin
        case (avs_address_in)
            `TS_REG_CTRL:   rd_mux = {31'h00000000, ctrl_fault};
            `TS_REG_STATUS: rd_mux = {21'h000000, status};
            `TS_REG_COARSE: rd_mux = coarse;
            `TS_REG_FINE:   rd_mux = {10'h000, fine};
            `TS_REG_TSTAT:  rd_mux = {25'h0000000, tstat};
            default:        rd_mux = `TS_ZERO32;
        endcase
    end

    // One wait state keeps the read data registered without a timing hazard.
    assign bus_req = (avs_read_in || avs_write_in) && avs_waitrequest_out;
    assign bus_wr  = avs_write_in && !avs_waitrequest_out;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= `TS_ZERO32;
        end else begin
            avs_waitrequest_out <= !bus_req;
            if (bus_req) begin
                avs_readdata_out <= rd_mux;
            end
        end
    end

    // Software fault bit.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_fault <= 1'b0;
        end else if (bus_wr && (avs_address_in == `TS_REG_CTRL)) begin
            ctrl_fault <= avs_writedata_in[0];
        end
    end

endmodule

// file: bench/tsync_asserts.sv
// Concurrent checks on the ports of the time synchronisation decision logic.
`timescale 1ns/1ps
module tsync_asserts (
    // Clock and reset
    input wire logic             clk_in,
    input wire logic             rst_in,
    // Watched ports
    input wire logic             avs_read_in,
    input wire logic             avs_write_in,
    input wire logic             avs_waitrequest_out,
    input wire logic             msg_valid_in,
    input wire tsync_pkg::msg_t  msg_in,
    input wire logic             msg_error_in,
    input wire logic             marker_in,
    input wire logic             fault_in,
    input wire tsync_pkg::mode_t mode_in,
    input wire logic [1:0]       go_sel_in,
    input wire logic             sync_out,
    input wire logic             sync_err_out,
    input wire logic             ext_err_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // The output flag lags the fault input two cycles, so both the input and the output copy are tested.
    sequence clean_msg(c);
        msg_valid_in && !msg_error_in && !fault_in && !ext_err_out && c;
    endsequence
    sequence clean_mark;
        marker_in && !fault_in && !ext_err_out;
    endsequence

    sync_cause_a: assert property (sync_out |-> $past(marker_in))
        else $error("sync pulse without a marker");
    err_cause_a: assert property (sync_err_out |-> $past(marker_in))
        else $error("sync error pulse without a marker");
    pulse_excl_a: assert property (!(sync_out && sync_err_out))
        else $error("sync and sync error together");
    ext_set_a: assert property (fault_in |-> ##2 ext_err_out)
        else $error("fault input did not raise the external error flag");
    ext_clear_a: assert property (
        $fell(ext_err_out) |-> $past(msg_valid_in, 2) && !$past(fault_in, 2))
        else $error("external error flag cleared without a clean message");
    sal_sync_a: assert property (
        clean_msg(mode_in == tsync_pkg::MODE_SAL) ##1 clean_mark |=> sync_out)
        else $error("stand-alone marker did not synchronise");
    go_zero_a: assert property (clean_msg(go_sel_in == 2'h0) ##1 clean_mark |=> sync_out)
        else $error("zero go-threshold marker did not synchronise");
    init_sync_a: assert property (
        (msg_valid_in && !msg_error_in && msg_in.init) ##1 marker_in |=> sync_out)
        else $error("initialisation message did not synchronise");
    bus_answer_a: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus request not answered in one cycle");
endmodule

// file: bench/msg_source.sv
// Behavioural model of the upstream time message decoder.
`timescale 1ns/1ps
module msg_source (
    // Clock
    input  wire logic       clk_in,
    // Decoder outputs
    output logic            msg_valid_out,
    output tsync_pkg::msg_t msg_out,
    output logic            msg_error_out,
    output logic            marker_out
);
    initial begin
        msg_valid_out = 1'b0;
        msg_out       = '0;
        msg_error_out = 1'b0;
        marker_out    = 1'b0;
    end

    // Markers come far sooner than the timeout; returns two edges after the marker.
    task automatic mark();
        marker_out <= 1'b1;
        @(posedge clk_in);
        marker_out <= 1'b0;
        @(posedge clk_in);
    endtask

    // Released payload lines toggle every cycle of the gap so stale contents cannot pass as valid.
    task automatic send(input logic [31:0] c, input logic i, input int gap);
        msg_valid_out <= 1'b1;
        msg_out       <= {c, i, c[6:0] ^ 7'h55};
        repeat (gap) begin
            @(posedge clk_in);
            msg_valid_out <= 1'b0;
            msg_out       <= ~msg_out;
        end
        mark();
    endtask

    // Two errors inside one message, then its marker.
    task automatic bad();
        repeat (2) begin
            msg_error_out <= 1'b1;
            @(posedge clk_in);
            msg_error_out <= 1'b0;
            @(posedge clk_in);
        end
        mark();
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the time synchronisation decision logic.
`timescale 1ns/1ps
`define CHECK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end

module tb;
    logic             clk_in           = 1'b0;
    logic             rst_in           = 1'b1;
    logic [2:0]       avs_address_in   = 3'h0;
    logic             avs_read_in      = 1'b0;
    logic             avs_write_in     = 1'b0;
    logic [31:0]      avs_writedata_in = 32'h0;
    logic [31:0]      avs_readdata_out;
    logic             avs_waitrequest_out;
    logic             msg_valid_in;
    tsync_pkg::msg_t  msg_in;
    logic             msg_error_in;
    logic             marker_in;
    logic             fault_in         = 1'b0;
    logic             drift_in         = 1'b0;
    tsync_pkg::mode_t mode_in          = tsync_pkg::MODE_SER;
    logic [1:0]       win_sel_in       = 2'h0;
    logic [1:0]       go_sel_in        = 2'h3;
    logic             sync_out;
    logic             sync_err_out;
    logic             ext_err_out;
    logic             marker_to_out;
    logic [31:0]      cur;
    logic [31:0]      d;
    int               ec;
    int               n_fail           = 0;
    int               n_checks         = 0;

    always #25 clk_in = ~clk_in;

    time_sync_decision_logic u_time_sync_decision_logic (
        .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .msg_valid_in(msg_valid_in),
        .msg_in(msg_in), .msg_error_in(msg_error_in), .marker_in(marker_in),
        .fault_in(fault_in), .drift_in(drift_in), .mode_in(mode_in), .win_sel_in(win_sel_in),
        .go_sel_in(go_sel_in), .sync_out(sync_out), .sync_err_out(sync_err_out),
        .ext_err_out(ext_err_out), .marker_to_out(marker_to_out)
    );

    msg_source u_msg_source (
        .clk_in(clk_in), .msg_valid_out(msg_valid_in), .msg_out(msg_in),
        .msg_error_out(msg_error_in), .marker_out(marker_in)
    );

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The leading edge keeps a new request from landing on the release of the last one.
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= wd;
        avs_read_in      <= !wr;
        avs_write_in     <= wr;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        d = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
        if (i == 50) begin
            n_fail++;
            stop_test();
        end
    endtask

    task automatic stat(input logic [31:0] m, input logic [31:0] v);
        bus(1'b0, 3'h1, 32'h0);
        `CHECK(d & m, v)
    endtask

    // Pulses are read at the edge after the answer cycle, before that edge's updates land.
    task automatic go(input logic [31:0] c, input logic i, input int gap, input logic [1:0] e);
        u_msg_source.send(c, i, gap);
        `CHECK({sync_out, sync_err_out}, e)
        if (e[1]) cur = c;
    endtask

    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        stat(32'h7ff, 32'h400);
        bus(1'b0, 3'h7, 32'h0);
        `CHECK(d, 32'h0)
        drift_in <= 1'b1;
        @(posedge clk_in);
        drift_in <= 1'b0;
        stat(32'h200, 32'h200);
        go(32'h10, 1'b0, 1, 2'b10);
        bus(1'b0, 3'h2, 32'h0);
        `CHECK(d, 32'h10)
        bus(1'b0, 3'h4, 32'h0);
        `CHECK(d[6:0], 7'h45)
        bus(1'b0, 3'h3, 32'h0);
        `CHECK(d[31:5], 27'h0)
        $display("Test first sync finished");
        for (int w = 0; w < 4; w++) begin
            win_sel_in <= w[1:0];
            go(cur, 1'b1, 1, 2'b10);
            go(cur + 1, 1'b0, (4 << (4 * w)) - 3, 2'b10);
            stat(32'h21f, 32'h0);
            go(cur, 1'b1, 1, 2'b10);
            go(cur + 1, 1'b0, (4 << (4 * w)) - 2, 2'b01);
            stat(32'h11f, 32'h106);
        end
        $display("Test window finished");
        u_msg_source.bad();
        `CHECK({sync_out, sync_err_out}, 2'b00)
        stat(32'h1f, 32'h9);
        u_msg_source.mark();
        stat(32'h1f, 32'hd);
        go_sel_in <= 2'h0;
        repeat (4) go(cur + 5, 1'b0, 1, 2'b10);
        stat(32'h1f, 32'h3);
        ec = 0;
        for (int s = 1; s < 3; s++) begin
            go_sel_in <= s[1:0];
            for (int k = ec; k < 4 * s - 1; k++) go(cur + 5, 1'b0, 1, 2'b01);
            stat(32'h1f, {ec[2:0] + 3'(4 * s - 1 - ec), 2'h2});
            go(cur + 5, 1'b0, 1, 2'b10);
            ec = 4 * s - 2;
        end
        go_sel_in <= 2'h3;
        repeat (2) go(cur + 5, 1'b0, 1, 2'b01);
        stat(32'h1f, 32'h1e);
        go(cur, 1'b1, 1, 2'b10);
        go(cur + 2, 1'b0, 1, 2'b01);
        stat(32'h9f, 32'h9e);
        $display("Test error counter finished");
        `CHECK(marker_to_out, 1'b0)
        mode_in  <= tsync_pkg::MODE_PAR;
        fault_in <= 1'b1;
        go(cur, 1'b1, 1, 2'b10);
        go(cur + 1, 1'b0, 1, 2'b01);
        `CHECK(ext_err_out, 1'b1)
        fault_in <= 1'b0;
        bus(1'b1, 3'h0, 32'h1);
        go(cur, 1'b1, 1, 2'b10);
        `CHECK(ext_err_out, 1'b1)
        bus(1'b1, 3'h0, 32'h0);
        go(cur, 1'b1, 1, 2'b10);
        `CHECK(ext_err_out, 1'b0)
        $display("Test external error finished");
        mode_in <= tsync_pkg::MODE_SAL;
        go(cur + 9, 1'b0, 1, 2'b10);
        fault_in <= 1'b1;
        go(cur + 1, 1'b0, 1, 2'b01);
        `CHECK(marker_to_out, 1'b0)
        $display("Test stand-alone finished");
        stop_test();
    end
endmodule

bind time_sync_decision_logic tsync_asserts u_tsync_asserts (
    .clk_in(clk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
    .msg_valid_in(msg_valid_in), .msg_in(msg_in), .msg_error_in(msg_error_in),
    .marker_in(marker_in), .fault_in(fault_in), .mode_in(mode_in), .go_sel_in(go_sel_in),
    .sync_out(sync_out), .sync_err_out(sync_err_out), .ext_err_out(ext_err_out)
);
